// File: logic/pig_cfg.svh
`ifndef PIG_CFG_SVH
`define PIG_CFG_SVH
// =============================================
// Register offsets.
`define PIG_OFF_PORTA 2'h0
`define PIG_OFF_PORTB 2'h1
`define PIG_OFF_PORTC 2'h2
`define PIG_OFF_CONFIG 2'h3
// =============================================
// Mode control words.
`define PIG_CW_A_M1_IN 8'hb0
`define PIG_CW_B_M1_IN 8'h86
`define PIG_CW_A_M1_OUT 8'ha0
`define PIG_CW_B_M1_OUT 8'h84
`define PIG_CW_A_M2_OUT 8'hc0
`define PIG_CW_A_M2_IN 8'hd0
// =============================================
// Field positions.
`define PIG_CW_MODE_BIT 7
`define PIG_BSR_SET_BIT 0
`define PIG_BSR_SEL_LSB 1
`define PIG_BSR_SEL_MSB 3
`define PIG_PC_LINE0 0
`define PIG_PC_LINE2 2
`define PIG_PC_LINE3 3
`define PIG_PC_LINE4 4
`define PIG_PC_LINE5 5
`define PIG_PC_LINE6 6
`define PIG_PC_LINE7 7
// =============================================
// Reset values.
`define PIG_PORT_RESET 8'h00
`define PIG_PORTC_RESET 8'hff
`endif

// File: logic/pig_pkg.sv
package pig_pkg;
   // Port A operating mode.
   typedef enum logic [2:0] {
      PIG_A_M0 = 3'b001,
      PIG_A_M1 = 3'b010,
      PIG_A_M2 = 3'b100
   } pig_amode_t;
   // Gate jumper position.
   typedef enum logic [1:0] {
      PIG_GATE_NC = 2'h0,
      PIG_GATE_L2 = 2'h1,
      PIG_GATE_L4 = 2'h2,
      PIG_GATE_L6 = 2'h3
   } pig_gate_t;
endpackage : pig_pkg

// File: logic/pig_gating.sv
// Behaviour
// - One configuration write sets or clears any one port-C line, others kept.
// - Writes 0xB0 and 0x86 make port A or B mode-1 inputs.
// - Writes 0xA0 and 0x84 make port A or B mode-1 outputs.
// - Writes 0xC0 and 0xD0 put port A in mode 2 output or input.
// - Words 09/0D/05 set lines 4/6/2; 08/0C/04 clear them.
// - Enables: port A input line 4, port B line 2, port A output line 6.
// - Jumper selects line 2, 4 or 6 as gate; unconnected blocks all.
// - Requests pass only while the selected gate line is low.
// - Only certain gates are valid per mode combination.
// - In mode 0, high on line 3 or line 0 requests an interrupt.
// - Mode 2 request: input enable and input full, or output enable and output not full.
`include "pig_cfg.svh"
module pig_gating
   import pig_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Host register port.
   input wire logic [1:0] addr,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [7:0] wrData,
   output logic [7:0] rdData,
   // Port handshake status.
   input wire logic portaInputFull,
   input wire logic portaOutputFullN,
   input wire logic portbFull,
   input wire logic [1:0] extLines,
   // Jumper and pins.
   input wire pig_gate_t gateSelectJumper,
   output logic [7:0] portaOut,
   output logic [7:0] portbOut,
   output logic [7:0] portcOut,
   output logic gateValid,
   output logic hostIrq
);
   logic [7:0] portaData_r;
   logic [7:0] portbData_r;
   logic [7:0] portcData_r;
   logic [7:0] portcData_nxt;
   pig_amode_t portaMode_r;
   logic portaDirIn_r;
   logic portbM1_r;
   logic portbDirIn_r;
   logic hostIrq_r;
   logic gateValid_r;
   logic [7:0] rdData_r;

   // =============================================
   // Decode.
   // Write strobes per register.
   wire wrPortA = wrStb && addr == `PIG_OFF_PORTA;
   wire wrPortB = wrStb && addr == `PIG_OFF_PORTB;
   wire wrPortC = wrStb && addr == `PIG_OFF_PORTC;
   wire wrCfg = wrStb && addr == `PIG_OFF_CONFIG;
   // Mode words have the top bit set; bit set/reset words have it clear.
   wire isMode = wrCfg && wrData[`PIG_CW_MODE_BIT];
   wire isBsr = wrCfg && !wrData[`PIG_CW_MODE_BIT];
   wire [2:0] bsrLine = wrData[`PIG_BSR_SEL_MSB:`PIG_BSR_SEL_LSB];
   wire bsrVal = wrData[`PIG_BSR_SET_BIT];

   // Next port-C value: one line changes on a bit set/reset word.
   always_comb begin
      portcData_nxt = portcData_r;
      if (wrPortC) begin
         portcData_nxt = wrData;
      end else if (isBsr) begin
         portcData_nxt[bsrLine] = bsrVal;
      end
   end

   // =============================================
   // Interrupt logic.
   // Enables live on port-C lines.
   wire enAIn = portcData_r[`PIG_PC_LINE4];
   wire enAOut = portcData_r[`PIG_PC_LINE6];
   wire enB = portcData_r[`PIG_PC_LINE2];
   wire reqA1 = portaDirIn_r ? (enAIn && portaInputFull) : (enAOut && portaOutputFullN);
   wire reqA2 = (enAIn && portaInputFull) || (enAOut && portaOutputFullN);
   wire reqB1 = enB && portbFull;
   wire reqExt = (portaMode_r == PIG_A_M0 || !portbM1_r) && (|extLines);
   wire portReq = (portaMode_r == PIG_A_M1 && reqA1) || (portaMode_r == PIG_A_M2 && reqA2)
      || (portbM1_r && reqB1) || reqExt;
   // Selected gate line, high when the jumper is unconnected.
   wire gateLine = gateSelectJumper == PIG_GATE_L2 ? portcData_r[`PIG_PC_LINE2] :
      gateSelectJumper == PIG_GATE_L4 ? portcData_r[`PIG_PC_LINE4] :
      gateSelectJumper == PIG_GATE_L6 ? portcData_r[`PIG_PC_LINE6] : 1'b1;
   wire irqNxt = portReq && !gateLine && gateSelectJumper != PIG_GATE_NC;
   // Gate validity per mode combination.
   wire line2Used = portbM1_r;
   wire line4Used = (portaMode_r == PIG_A_M1 && portaDirIn_r) || portaMode_r == PIG_A_M2;
   wire line6Used = (portaMode_r == PIG_A_M1 && !portaDirIn_r) || portaMode_r == PIG_A_M2;
   wire anyIntMode = portaMode_r != PIG_A_M0 || portbM1_r;
   wire validNxt = gateSelectJumper == PIG_GATE_L2 ? !line2Used && anyIntMode :
      gateSelectJumper == PIG_GATE_L4 ? !line4Used && anyIntMode :
      gateSelectJumper == PIG_GATE_L6 ? !line6Used && anyIntMode : 1'b0;

   // Read mux.
   wire [7:0] rdNxt = addr == `PIG_OFF_PORTA ? portaData_r :
      addr == `PIG_OFF_PORTB ? portbData_r :
      addr == `PIG_OFF_PORTC ? portcData_r : 8'h00;

   // =============================================
   // Registers.
   // Data registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         portaData_r <= `PIG_PORT_RESET;
         portbData_r <= `PIG_PORT_RESET;
         portcData_r <= `PIG_PORTC_RESET;
      end else begin
         if (wrPortA) portaData_r <= wrData;
         if (wrPortB) portbData_r <= wrData;
         portcData_r <= portcData_nxt;
      end
   end

   // Mode registers from control words.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         portaMode_r <= PIG_A_M0;
         portaDirIn_r <= 1'b1;
         portbM1_r <= 1'b0;
         portbDirIn_r <= 1'b1;
      end else if (isMode) begin
         unique case (wrData)
            `PIG_CW_A_M1_IN: begin
               portaMode_r <= PIG_A_M1;
               portaDirIn_r <= 1'b1;
            end
            `PIG_CW_B_M1_IN: begin
               portbM1_r <= 1'b1;
               portbDirIn_r <= 1'b1;
            end
            `PIG_CW_A_M1_OUT: begin
               portaMode_r <= PIG_A_M1;
               portaDirIn_r <= 1'b0;
            end
            `PIG_CW_B_M1_OUT: begin
               portbM1_r <= 1'b1;
               portbDirIn_r <= 1'b0;
            end
            `PIG_CW_A_M2_OUT: begin
               portaMode_r <= PIG_A_M2;
               portaDirIn_r <= 1'b0;
            end
            `PIG_CW_A_M2_IN: begin
               portaMode_r <= PIG_A_M2;
               portaDirIn_r <= 1'b1;
            end
            default: begin // Any other mode word drops both ports to plain mode.
               portaMode_r <= PIG_A_M0;
               portbM1_r <= 1'b0;
            end
         endcase
      end
   end

   // Output registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hostIrq_r <= 1'b0;
         gateValid_r <= 1'b0;
         rdData_r <= 8'h00;
      end else begin
         hostIrq_r <= irqNxt;
         gateValid_r <= validNxt;
         if (rdStb) rdData_r <= rdNxt;
      end
   end

   assign hostIrq = hostIrq_r;
   assign gateValid = gateValid_r;
   assign rdData = rdData_r;
   assign portaOut = portaData_r;
   assign portbOut = portbData_r;
   assign portcOut = portcData_r;

   // =============================================
   // Assertions.
   a_bsr_one_line: assert property (@(posedge clk) disable iff (!rst_n)
      isBsr |=> portcData_r == (($past(portcData_r) & ~(8'h01 << $past(bsrLine)))
         | (8'($past(bsrVal)) << $past(bsrLine))))
      else $error("Bit set/reset changed the wrong lines.");
   a_bsr_set4: assert property (@(posedge clk) disable iff (!rst_n)
      wrCfg && wrData == 8'h09 |=> portcData_r[`PIG_PC_LINE4])
      else $error("Word 09 did not set line 4.");
   a_mode_a_in: assert property (@(posedge clk) disable iff (!rst_n)
      wrCfg && wrData == `PIG_CW_A_M1_IN |=> portaMode_r == PIG_A_M1 && portaDirIn_r)
      else $error("Port A mode-1 input not taken.");
   a_mode_b_out: assert property (@(posedge clk) disable iff (!rst_n)
      wrCfg && wrData == `PIG_CW_B_M1_OUT |=> portbM1_r && !portbDirIn_r)
      else $error("Port B mode-1 output not taken.");
   a_mode_two: assert property (@(posedge clk) disable iff (!rst_n)
      wrCfg && wrData == `PIG_CW_A_M2_IN |=> portaMode_r == PIG_A_M2 && portaDirIn_r)
      else $error("Port A mode 2 input not taken.");
   a_gate_nc: assert property (@(posedge clk) disable iff (!rst_n)
      gateSelectJumper == PIG_GATE_NC |=> !hostIrq)
      else $error("Interrupt passed with jumper unconnected.");
   a_gate_high: assert property (@(posedge clk) disable iff (!rst_n)
      gateLine |=> !hostIrq)
      else $error("Interrupt passed with gate line high.");
   a_irq_follow: assert property (@(posedge clk) disable iff (!rst_n)
      portReq && !gateLine && gateSelectJumper != PIG_GATE_NC |=> hostIrq)
      else $error("Gated request did not reach the host.");
   a_ext_irq: assert property (@(posedge clk) disable iff (!rst_n)
      portaMode_r == PIG_A_M0 && (|extLines) && !gateLine
         && gateSelectJumper != PIG_GATE_NC |=> hostIrq)
      else $error("External line did not interrupt.");
   a_mode2_req: assert property (@(posedge clk) disable iff (!rst_n)
      portaMode_r == PIG_A_M2 && enAIn && portaInputFull |-> portReq)
      else $error("Mode 2 input request missing.");
   a_mode2_out: assert property (@(posedge clk) disable iff (!rst_n)
      portaMode_r == PIG_A_M2 && enAOut && portaOutputFullN |-> portReq)
      else $error("Mode 2 output request missing.");
   a_enable_b: assert property (@(posedge clk) disable iff (!rst_n)
      portbM1_r && enB && portbFull |-> portReq)
      else $error("Port B request missing with its enable set.");
   a_valid_nc: assert property (@(posedge clk) disable iff (!rst_n)
      gateSelectJumper == PIG_GATE_NC |=> !gateValid)
      else $error("Unconnected jumper reported as usable.");
   a_valid_m2b1: assert property (@(posedge clk) disable iff (!rst_n)
      portaMode_r == PIG_A_M2 && portbM1_r |=> !gateValid)
      else $error("Gate reported usable with port A mode 2 and port B mode 1.");
endmodule : pig_gating

// File: tb/pig_host_model.sv
// ==========================================
// Host side of the register port.
module pig_host_model (
   // Clock.
   input wire logic clk,
   // Register bus towards the block.
   output logic [1:0] addr,
   output logic wrStb,
   output logic rdStb,
   output logic [7:0] wrData,
   input wire logic [7:0] rdData
);
   timeunit 1ns;
   timeprecision 100ps;
   // The bus is idle until the first access.
   initial begin
      addr = 2'h0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      wrData = 8'h00;
   end
   // One write; data goes stale once the strobe is gone.
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wrData = d;
      wrStb = 1'b1;
      @(posedge clk);
      #1;
      wrStb = 1'b0;
      wrData = ~d;
   endtask : wr
   // One read; data is registered at the taking edge.
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      rdStb = 1'b1;
      @(posedge clk);
      #1;
      rdStb = 1'b0;
      d = rdData;
   endtask : rd
endmodule : pig_host_model

// File: tb/tb_top.sv
`define CHK(g, e, m) begin cmpCount++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
// ==========================================
// Bench top.
module tb_top;
   import pig_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, inFull = 1'b0, outFullN = 1'b0, bFull = 1'b0;
   logic [1:0] addr, extLines = 2'h0;
   logic wrStb, rdStb;
   logic [7:0] wrData, rdData, portaOut, portbOut, portcOut, rv;
   logic gateValid, hostIrq;
   pig_gate_t jmp = PIG_GATE_NC;
   int errors = 0, cmpCount = 0;
   // Clock generator.
   always #5 clk = ~clk;
   pig_gating i_pig_gating (.clk(clk), .rst_n(rst_n), .addr(addr), .wrStb(wrStb),
      .rdStb(rdStb), .wrData(wrData), .rdData(rdData), .portaInputFull(inFull),
      .portaOutputFullN(outFullN), .portbFull(bFull), .extLines(extLines),
      .gateSelectJumper(jmp), .portaOut(portaOut), .portbOut(portbOut),
      .portcOut(portcOut), .gateValid(gateValid), .hostIrq(hostIrq));
   pig_host_model i_host (.clk(clk), .addr(addr), .wrStb(wrStb), .rdStb(rdStb),
      .wrData(wrData), .rdData(rdData));
   // Lets a write reach the interrupt output.
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // Ends the run with the verdict.
   task automatic close_out();
      if (errors == 0 && cmpCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   // Data registers at their offsets.
   task automatic t_regs();
      `CHK(portcOut, 8'hff, "port C reset")
      `CHK(hostIrq, 1'b0, "irq at reset")
      i_host.wr(2'h0, 8'h5a);
      i_host.wr(2'h1, 8'ha5);
      i_host.rd(2'h0, rv);
      `CHK(rv, 8'h5a, "port A read")
      i_host.rd(2'h1, rv);
      `CHK(rv, 8'ha5, "port B read")
      `CHK(portaOut, 8'h5a, "port A out")
      `CHK(portbOut, 8'ha5, "port B out")
      i_host.rd(2'h3, rv);
      `CHK(rv, 8'h00, "configuration reads zero")
   endtask : t_regs
   // Single-line set and clear words, one after another.
   task automatic t_bsr();
      logic [7:0] w[6] = '{8'h09, 8'h0d, 8'h05, 8'h08, 8'h0c, 8'h04};
      logic [7:0] e[6] = '{8'h10, 8'h50, 8'h54, 8'h44, 8'h04, 8'h00};
      i_host.wr(2'h2, 8'h00);
      for (int i = 0; i < 6; i++) begin
         i_host.wr(2'h3, w[i]);
         i_host.rd(2'h2, rv);
         `CHK(rv, e[i], "line set or clear")
      end
   endtask : t_bsr
   // External request in mode 0, gated on line 2.
   task automatic t_ext();
      i_host.wr(2'h2, 8'hff);
      jmp = PIG_GATE_L2;
      i_host.wr(2'h3, 8'h04);
      extLines = 2'h1;
      settle();
      `CHK(hostIrq, 1'b1, "line 0 request")
      extLines = 2'h2;
      settle();
      `CHK(hostIrq, 1'b1, "line 3 request")
      i_host.wr(2'h3, 8'h05);
      settle();
      `CHK(hostIrq, 1'b0, "gate high blocks")
      extLines = 2'h0;
   endtask : t_ext
   // Mask, program, enable, open gate, jumper off, close gate.
   task automatic mode_irq(input logic [7:0] cw, en, clr, st, input pig_gate_t j,
      input logic [2:0] s, input logic gv);
      i_host.wr(2'h2, 8'hff);
      i_host.wr(2'h3, 8'h80); // An unlisted mode word returns both ports to plain mode.
      i_host.wr(2'h3, cw);
      jmp = j;
      i_host.wr(2'h3, en);
      {inFull, outFullN, bFull} = s;
      settle();
      `CHK(hostIrq, 1'b0, "gate high masks")
      i_host.wr(2'h3, clr);
      settle();
      `CHK(hostIrq, 1'b1, "request passes")
      `CHK(gateValid, gv, "gate usability")
      jmp = PIG_GATE_NC;
      settle();
      `CHK(hostIrq, 1'b0, "unconnected jumper")
      jmp = j;
      i_host.wr(2'h3, st);
      settle();
      `CHK(hostIrq, 1'b0, "gate closed again")
      {inFull, outFullN, bFull} = 3'h0;
   endtask : mode_irq
   // Gate usability with port A in mode 2 and port B plain, then in mode 1.
   task automatic t_combo();
      jmp = PIG_GATE_L6;
      settle();
      `CHK(gateValid, 1'b0, "line 6 unusable in mode 2")
      jmp = PIG_GATE_L2;
      settle();
      `CHK(gateValid, 1'b1, "line 2 usable with port B plain")
      i_host.wr(2'h3, 8'h86);
      settle();
      `CHK(gateValid, 1'b0, "no gate with port B in mode 1")
   endtask : t_combo
   // Reset in mid-run restores the masked, plain-mode state.
   task automatic t_reset();
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      `CHK(portcOut, 8'hff, "gate lines high after reset")
      `CHK(portaOut, 8'h00, "port A cleared by reset")
      `CHK(hostIrq, 1'b0, "irq after reset")
      settle();
      `CHK(gateValid, 1'b0, "no interrupt mode after reset")
   endtask : t_reset
   // Main sequence.
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_regs();
      t_bsr();
      t_ext();
      mode_irq(8'hb0, 8'h09, 8'h0c, 8'h0d, PIG_GATE_L6, 3'h4, 1'b1);
      mode_irq(8'h86, 8'h05, 8'h0c, 8'h0d, PIG_GATE_L6, 3'h1, 1'b1);
      mode_irq(8'h84, 8'h05, 8'h08, 8'h09, PIG_GATE_L4, 3'h1, 1'b1);
      mode_irq(8'ha0, 8'h0d, 8'h08, 8'h09, PIG_GATE_L4, 3'h2, 1'b1);
      mode_irq(8'hc0, 8'h0d, 8'h04, 8'h05, PIG_GATE_L2, 3'h2, 1'b1);
      mode_irq(8'hd0, 8'h09, 8'h04, 8'h05, PIG_GATE_L2, 3'h4, 1'b1);
      t_combo();
      t_reset();
      close_out();
   end
endmodule : tb_top
